// ### logic/bmu_map.svh
// constants for the bit manipulation unit: flag bit positions, flag reset value and bus byte values
// assumes the includer wants plain defines, one copy only
//
// Functional notes
// - set op forces selected bit to one
// - clear op forces selected bit to zero
// - invert op complements the selected bit
// - test op writes inverted bit into zero
// - set/clear/invert/test: immediate or register bit number
// - carry becomes carry and bit
// - carry becomes carry and inverted bit
// - carry becomes carry or bit
// - carry becomes carry or inverted bit
// - carry becomes carry xor bit
// - carry becomes carry xor inverted bit
// - load copies bit into carry
// - load inverse copies inverted bit into carry
// - store writes carry into selected bit
// - store inverse writes inverted carry into bit
// - inverted variants use immediate bit number only
// - modifying ops are whole byte read-modify-write
// - read, modify, then write same address
// - write-only register reads as all ones
// - carry is the condition code carry bit
`ifndef BMU_MAP_SVH
`define BMU_MAP_SVH
// ************************************************************
// condition code bit positions, reset value and bus byte values
// ************************************************************
`define BMU_CCR_C_POS   0
`define BMU_CCR_V_POS   1
`define BMU_CCR_Z_POS   2
`define BMU_CCR_N_POS   3
`define BMU_CCR_RST     8'h00
`define BMU_WO_READ_VAL 8'hff
`define BMU_BUS_IDLE    8'h00
`endif

// ### logic/bmu_pkg.sv
// types of the bit manipulation unit
// assumes bmu_map.svh is compiled with it
package bmu_pkg;
  typedef enum logic [3:0] {
    BMU_OP_SET   = 4'h0,
    BMU_OP_CLR   = 4'h1,
    BMU_OP_NOT   = 4'h2,
    BMU_OP_TST   = 4'h3,
    BMU_OP_AND   = 4'h4,
    BMU_OP_IAND  = 4'h5,
    BMU_OP_OR    = 4'h6,
    BMU_OP_IOR   = 4'h7,
    BMU_OP_XOR   = 4'h8,
    BMU_OP_IXOR  = 4'h9,
    BMU_OP_LD    = 4'ha,
    BMU_OP_ILD   = 4'hb,
    BMU_OP_ST    = 4'hc,
    BMU_OP_IST   = 4'hd
  } bmu_op_t;
  typedef enum logic [4:0] {
    BMU_S_IDLE  = 5'h01,
    BMU_S_READ  = 5'h02,
    BMU_S_WAIT  = 5'h04,
    BMU_S_WRITE = 5'h08,
    BMU_S_DONE  = 5'h10
  } bmu_state_t;
endpackage

// ### logic/bmu_alu.sv
// combinational bit operation on one byte and the carry flag
// assumes the caller registers everything it produces
`timescale 1ns/100ps
`include "bmu_map.svh"
module bmu_alu
  import bmu_pkg::*;
(
  input  wire bmu_op_t    op,
  input  wire logic [7:0] data_in,
  input  wire logic [2:0] bit_no,
  input  wire logic       carry_in,
  output logic      [7:0] data_out,
  output logic            carry_out,
  output logic            zero_out,
  output logic            writes_byte,
  output logic            writes_carry,
  output logic            writes_zero
);
  logic sel;
  logic [7:0] mask;
  // ************************************************************
  // operation table
  // ************************************************************
  // one mask serves all byte changes so other bits pass unchanged
  always_comb begin
    mask         = 8'h01 << bit_no;
    sel          = data_in[bit_no];
    data_out     = data_in;
    carry_out    = carry_in;
    zero_out     = 1'b0;
    writes_byte  = 1'b0;
    writes_carry = 1'b0;
    writes_zero  = 1'b0;
    case (op)
      BMU_OP_SET: begin
        data_out = data_in | mask;
        writes_byte = 1'b1;
      end
      BMU_OP_CLR: begin
        data_out = data_in & ~mask;
        writes_byte = 1'b1;
      end
      BMU_OP_NOT: begin
        data_out = data_in ^ mask;
        writes_byte = 1'b1;
      end
      BMU_OP_TST: begin
        zero_out = ~sel;
        writes_zero = 1'b1;
      end
      BMU_OP_AND: begin
        carry_out = carry_in & sel;
        writes_carry = 1'b1;
      end
      BMU_OP_IAND: begin
        carry_out = carry_in & ~sel;
        writes_carry = 1'b1;
      end
      BMU_OP_OR: begin
        carry_out = carry_in | sel;
        writes_carry = 1'b1;
      end
      BMU_OP_IOR: begin
        carry_out = carry_in | ~sel;
        writes_carry = 1'b1;
      end
      BMU_OP_XOR: begin
        carry_out = carry_in ^ sel;
        writes_carry = 1'b1;
      end
      BMU_OP_IXOR: begin
        carry_out = carry_in ^ ~sel;
        writes_carry = 1'b1;
      end
      BMU_OP_LD: begin
        carry_out = sel;
        writes_carry = 1'b1;
      end
      BMU_OP_ILD: begin
        carry_out = ~sel;
        writes_carry = 1'b1;
      end
      BMU_OP_ST: begin
        data_out = carry_in ? (data_in | mask) : (data_in & ~mask);
        writes_byte = 1'b1;
      end
      BMU_OP_IST: begin
        data_out = carry_in ? (data_in & ~mask) : (data_in | mask);
        writes_byte = 1'b1;
      end
      default: begin
        data_out = data_in;
      end
    endcase
  end
endmodule

// ### logic/bmu_top.sv
// bit manipulation unit: executes one bit instruction per start pulse
// assumes operands come from the register file or a byte bus with a
// read ready answer; memory writes are taken in one cycle
`timescale 1ns/100ps
`include "bmu_map.svh"
module bmu_top
  import bmu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire bmu_op_t    op,
  input  wire logic       use_mem,
  input  wire logic       bit_from_reg,
  input  wire logic [2:0] bit_imm,
  input  wire logic [7:0] bit_reg,
  input  wire logic [7:0] reg_data,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic       mem_write_only,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       mem_rready,
  output logic            busy,
  output logic            done,
  output logic            illegal,
  output logic [7:0]      condition_code_register,
  output logic            reg_we,
  output logic [7:0]      reg_wdata,
  output logic            mem_rd,
  output logic            mem_wr,
  output logic [15:0]     mem_addr,
  output logic [7:0]      mem_wdata
);
  bmu_state_t state_reg;
  bmu_state_t state_next;
  bmu_op_t    op_reg;
  logic [2:0] bit_no_reg;
  logic       mem_reg;
  logic [7:0] byte_reg;
  logic [7:0] alu_data;
  logic       alu_carry;
  logic       alu_zero;
  logic       alu_wb;
  logic       alu_wc;
  logic       alu_wz;
  logic       inv_variant;
  logic       start_ok;

  // ************************************************************
  // request decode
  // ************************************************************
  function automatic logic bmu_is_inverted(input bmu_op_t o);
    bmu_is_inverted = (o == BMU_OP_IAND) || (o == BMU_OP_IOR) ||
                      (o == BMU_OP_IXOR) || (o == BMU_OP_ILD) ||
                      (o == BMU_OP_IST);
  endfunction
  // a register-sourced bit number on an inverted op is refused, not guessed
  assign inv_variant = bmu_is_inverted(op);
  assign start_ok = start && (state_reg == BMU_S_IDLE) &&
                    !(inv_variant && bit_from_reg);

  bmu_alu u_alu (
    .op           (op_reg),
    .data_in      (byte_reg),
    .bit_no       (bit_no_reg),
    .carry_in     (condition_code_register[`BMU_CCR_C_POS]),
    .data_out     (alu_data),
    .carry_out    (alu_carry),
    .zero_out     (alu_zero),
    .writes_byte  (alu_wb),
    .writes_carry (alu_wc),
    .writes_zero  (alu_wz)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  // read, modify, write in that order; never overlapped
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BMU_S_IDLE:  if (start_ok) begin
        state_next = use_mem ? BMU_S_READ : BMU_S_DONE;
      end
      BMU_S_READ:  state_next = BMU_S_WAIT;
      BMU_S_WAIT:  if (mem_rready || mem_write_only) begin
        state_next = alu_wb_pending() ? BMU_S_WRITE : BMU_S_DONE;
      end
      BMU_S_WRITE: state_next = BMU_S_DONE;
      BMU_S_DONE:  state_next = BMU_S_IDLE;
      default:     state_next = BMU_S_IDLE;
    endcase
  end
  function automatic logic alu_wb_pending();
    alu_wb_pending = (op_reg == BMU_OP_SET) || (op_reg == BMU_OP_CLR) ||
                     (op_reg == BMU_OP_NOT) || (op_reg == BMU_OP_ST) ||
                     (op_reg == BMU_OP_IST);
  endfunction

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= BMU_S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // operand capture
  // ************************************************************
  // bit number from immediate or the low three bits of a register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg     <= BMU_OP_TST;
      bit_no_reg <= 3'h0;
      mem_reg    <= 1'b0;
      mem_addr   <= 16'h0000;
    end else if (start_ok) begin
      op_reg     <= op;
      bit_no_reg <= bit_from_reg ? bit_reg[2:0] : bit_imm;
      mem_reg    <= use_mem;
      mem_addr   <= mem_addr_in;
    end
  end

  // whole byte is held so the write returns all eight bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_reg <= `BMU_BUS_IDLE;
    end else if (start_ok && !use_mem) begin
      byte_reg <= reg_data;
    end else if (state_reg == BMU_S_WAIT) begin
      // write-only location reads as ones; other bits may get set
      if (mem_write_only) begin
        byte_reg <= `BMU_WO_READ_VAL;
      end else if (mem_rready) begin
        byte_reg <= mem_rdata;
      end
    end
  end

  // ************************************************************
  // bus strobes
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= `BMU_BUS_IDLE;
    end else begin
      // read strobe stands for the single read state cycle
      mem_rd <= (state_next == BMU_S_READ);
      mem_wr <= (state_next == BMU_S_WRITE);
      if (state_next == BMU_S_WRITE) begin
        mem_wdata <= alu_data_next();
      end
    end
  end
  // next byte for write uses the byte being captured this cycle
  function automatic logic [7:0] alu_data_next();
    logic [7:0] b;
    logic [7:0] m;
    b = mem_write_only ? `BMU_WO_READ_VAL : mem_rdata;
    m = 8'h01 << bit_no_reg;
    case (op_reg)
      BMU_OP_SET: alu_data_next = b | m;
      BMU_OP_CLR: alu_data_next = b & ~m;
      BMU_OP_NOT: alu_data_next = b ^ m;
      BMU_OP_ST:  alu_data_next = condition_code_register[`BMU_CCR_C_POS] ? (b | m) : (b & ~m);
      BMU_OP_IST: alu_data_next = condition_code_register[`BMU_CCR_C_POS] ? (b & ~m) : (b | m);
      default:    alu_data_next = b;
    endcase
  endfunction

  // ************************************************************
  // register write back and flags
  // ************************************************************
  // register targets commit in the done cycle from the held byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_we    <= 1'b0;
      reg_wdata <= `BMU_BUS_IDLE;
    end else begin
      reg_we <= (state_reg == BMU_S_DONE) && !mem_reg && alu_wb;
      if ((state_reg == BMU_S_DONE) && !mem_reg && alu_wb) begin
        reg_wdata <= alu_data;
      end
    end
  end

  // only carry or zero moves; the other flags are untouched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      condition_code_register <= `BMU_CCR_RST;
    end else if (state_reg == BMU_S_DONE) begin
      if (alu_wc) begin
        condition_code_register[`BMU_CCR_C_POS] <= alu_carry;
      end
      if (alu_wz) begin
        condition_code_register[`BMU_CCR_Z_POS] <= alu_zero;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      illegal <= 1'b0;
    end else begin
      busy    <= (state_next != BMU_S_IDLE);
      done    <= (state_reg == BMU_S_DONE);
      illegal <= start && (state_reg == BMU_S_IDLE) &&
                 inv_variant && bit_from_reg;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence rmw_read_s;
    (state_reg == BMU_S_READ);
  endsequence
  sequence rmw_write_s;
    (state_reg == BMU_S_WRITE);
  endsequence

  // ordering of the read, modify and write steps
  write_after_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rmw_write_s |-> $past(state_reg == BMU_S_WAIT))
    else $error("write not preceded by read wait");
  read_then_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rmw_read_s ##1 (mem_write_only && alu_wb) |=> rmw_write_s)
    else $error("write-only rmw skipped write");
  read_strobe_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rmw_read_s |-> mem_rd && !mem_wr)
    else $error("read state without lone read strobe");
  write_strobe_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rmw_write_s |-> mem_wr && !mem_rd)
    else $error("write state without lone write strobe");
  addr_stable_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg != BMU_S_IDLE) |=> $stable(mem_addr))
    else $error("address moved mid sequence");
  // a write-only location hands back ones, so other bits may be set
  wo_reads_ones_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == BMU_S_WAIT && mem_write_only)
    |=> byte_reg == `BMU_WO_READ_VAL)
    else $error("write-only byte not all ones");

  // byte changes touch the selected bit and nothing else
  set_bit_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mem_wr && op_reg == BMU_OP_SET) |-> mem_wdata[bit_no_reg])
    else $error("set op wrote zero bit");
  clr_bit_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mem_wr && op_reg == BMU_OP_CLR) |-> !mem_wdata[bit_no_reg])
    else $error("clear op wrote one bit");
  invert_bit_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mem_wr && op_reg == BMU_OP_NOT)
    |-> mem_wdata[bit_no_reg] != byte_reg[bit_no_reg])
    else $error("invert op kept the bit");
  store_carry_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mem_wr && op_reg == BMU_OP_ST)
    |-> mem_wdata[bit_no_reg] == condition_code_register[`BMU_CCR_C_POS])
    else $error("store op did not write carry");
  store_inverse_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mem_wr && op_reg == BMU_OP_IST)
    |-> mem_wdata[bit_no_reg] != condition_code_register[`BMU_CCR_C_POS])
    else $error("store inverse op wrote carry");
  others_kept_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    mem_wr |-> ((mem_wdata ^ byte_reg) & ~(8'h01 << bit_no_reg)) == 8'h00)
    else $error("write changed an unselected bit");

  // flag results and the flags that must not move
  test_zero_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == BMU_S_DONE && op_reg == BMU_OP_TST)
    |=> condition_code_register[`BMU_CCR_Z_POS] == ~$past(byte_reg[bit_no_reg]))
    else $error("zero flag not inverse of bit");
  load_carry_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == BMU_S_DONE && op_reg == BMU_OP_LD)
    |=> condition_code_register[`BMU_CCR_C_POS] == $past(byte_reg[bit_no_reg]))
    else $error("carry not loaded from bit");
  load_inverse_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == BMU_S_DONE && op_reg == BMU_OP_ILD)
    |=> condition_code_register[`BMU_CCR_C_POS] == !$past(byte_reg[bit_no_reg]))
    else $error("carry not loaded from inverted bit");
  carry_and_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == BMU_S_DONE && op_reg == BMU_OP_AND)
    |=> condition_code_register[`BMU_CCR_C_POS] ==
        ($past(condition_code_register[`BMU_CCR_C_POS]) & $past(byte_reg[bit_no_reg])))
    else $error("carry not anded with bit");
  carry_xor_inv_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == BMU_S_DONE && op_reg == BMU_OP_IXOR)
    |=> condition_code_register[`BMU_CCR_C_POS] ==
        ($past(condition_code_register[`BMU_CCR_C_POS]) ^ !$past(byte_reg[bit_no_reg])))
    else $error("carry not xored with inverted bit");
  flags_kept_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> condition_code_register[7:3] == $past(condition_code_register[7:3]) && condition_code_register[1] == $past(condition_code_register[1]))
    else $error("unrelated flag changed");
  // test and carry ops leave the operand alone, in memory or register
  operand_kept_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg != BMU_S_IDLE && !alu_wb) |=> !reg_we && !mem_wr)
    else $error("non-modifying op wrote its operand");

  // request decode
  inv_reg_refused_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (start && state_reg == BMU_S_IDLE && inv_variant && bit_from_reg)
    |=> illegal && !busy)
    else $error("inverted op accepted register bit");
  reg_bit_no_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (start_ok && bit_from_reg) |=> bit_no_reg == $past(bit_reg[2:0]))
    else $error("register bit number not low three bits");
endmodule

// ### verif/bmu_mem_model.sv
// byte memory that answers the unit's read and write pulses
// assumes one request pulse at a time and that the low address byte
// is enough to tell the test locations apart
`timescale 1ns/100ps
module bmu_mem_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_rready
);
  logic [7:0] mem_arr [256];
  logic [1:0] cnt_reg;
  logic       pend_reg;
  logic [7:0] addr_reg;
  // ********
  // read answer, lat extra cycles late
  // ********
  // outside the answer cycle the data flips every cycle, so a late
  // sample of the read bus cannot pass by luck
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_reg   <= 1'b0;
      cnt_reg    <= 2'h0;
      addr_reg   <= 8'h00;
      mem_rready <= 1'b0;
      mem_rdata  <= 8'h00;
    end else begin
      mem_rready <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      if (mem_rd) begin
        pend_reg <= 1'b1;
        cnt_reg  <= lat;
        addr_reg <= mem_addr[7:0];
      end else if (pend_reg && cnt_reg == 2'h0) begin
        pend_reg   <= 1'b0;
        mem_rready <= 1'b1;
        mem_rdata  <= mem_arr[addr_reg];
      end else if (pend_reg) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
  // writes take one cycle; plain always so the bench may preload
  always @(posedge clk) begin
    if (mem_wr) begin
      mem_arr[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule

// ### verif/bmu_top_tb.sv
// self-checking bench of the bit manipulation unit
// assumes bmu_pkg and bmu_mem_model are compiled before it
`timescale 1ns/100ps
module bmu_top_tb;
  import bmu_pkg::*;
  logic        clk, sys_rst, start, use_mem, bit_from_reg, mem_write_only;
  bmu_op_t     op;
  logic [2:0]  bit_imm;
  logic [7:0]  bit_reg, reg_data, mem_rdata, condition_code_register, reg_wdata, mem_wdata;
  logic [15:0] mem_addr_in, mem_addr, rd_addr, wr_addr;
  logic        mem_rready, busy, done, illegal, reg_we, mem_rd, mem_wr;
  logic [1:0]  lat;
  logic [7:0]  exp_ccr, wr_data, we_data;
  logic        saw_done, saw_ill, saw_rd, saw_wr, saw_we, rd_first, wo_mode;
  logic        saw_busy;
  int          mismatches, comparisons, cycles;

  bmu_top i_bmu_top (.clk, .sys_rst, .start, .op, .use_mem, .bit_from_reg,
    .bit_imm, .bit_reg, .reg_data, .mem_addr_in, .mem_write_only,
    .mem_rdata, .mem_rready, .busy, .done, .illegal, .condition_code_register, .reg_we,
    .reg_wdata, .mem_rd, .mem_wr, .mem_addr, .mem_wdata);
  bmu_mem_model i_bmu_mem_model (.clk, .sys_rst, .lat, .mem_rd, .mem_wr,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_rready);

  // ********
  // clock, hang guard, reporting
  // ********
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // a few hundred cycles cover every scenario, so 20000 leaves a wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  // ********
  // one instruction: start pulse, then watch the ports until done
  // ********
  task automatic run_op(bmu_op_t o, logic m, logic fr, logic [2:0] bi,
                        logic [7:0] br, logic [7:0] d, logic [15:0] a);
    @(posedge clk);
    op             <= o;
    use_mem        <= m;
    bit_from_reg   <= fr;
    bit_imm        <= bi;
    bit_reg        <= br;
    reg_data       <= d;
    mem_addr_in    <= a;
    mem_write_only <= wo_mode;
    start          <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    {saw_done, saw_ill, saw_rd, saw_wr, saw_we, rd_first, saw_busy} = 7'h00;
    // pulses stand one cycle, so every cycle is looked at
    for (int i = 0; i < 40 && !saw_done; i++) begin
      #1;
      if (mem_rd === 1'b1) begin
        saw_rd   = 1'b1;
        rd_addr  = mem_addr;
        rd_first = !saw_wr;
      end
      if (mem_wr === 1'b1) begin
        saw_wr  = 1'b1;
        wr_addr = mem_addr;
        wr_data = mem_wdata;
      end
      if (reg_we === 1'b1) begin
        saw_we  = 1'b1;
        we_data = reg_wdata;
      end
      saw_ill  = saw_ill | (illegal === 1'b1);
      saw_busy = saw_busy | (busy === 1'b1);
      saw_done = (done === 1'b1);
      if (!saw_done) @(posedge clk);
    end
  endtask

  // expected result worked out here, then the run judged against it
  task automatic do_op(bmu_op_t o, logic m, logic fr, logic [2:0] bi,
                       logic [7:0] br, logic [7:0] d, logic [15:0] a);
    logic [2:0] b;
    logic [7:0] v, nd;
    logic       nc, nz, wb;
    b  = fr ? br[2:0] : bi;
    v  = (m && wo_mode) ? 8'hff : d;
    nd = v;
    nc = exp_ccr[0];
    nz = exp_ccr[2];
    wb = 1'b0;
    case (o)
      BMU_OP_SET:  begin nd[b] = 1'b1; wb = 1'b1; end
      BMU_OP_CLR:  begin nd[b] = 1'b0; wb = 1'b1; end
      BMU_OP_NOT:  begin nd[b] = ~v[b]; wb = 1'b1; end
      BMU_OP_TST:  nz = ~v[b];
      BMU_OP_AND:  nc = nc & v[b];
      BMU_OP_IAND: nc = nc & ~v[b];
      BMU_OP_OR:   nc = nc | v[b];
      BMU_OP_IOR:  nc = nc | ~v[b];
      BMU_OP_XOR:  nc = nc ^ v[b];
      BMU_OP_IXOR: nc = nc ^ ~v[b];
      BMU_OP_LD:   nc = v[b];
      BMU_OP_ILD:  nc = ~v[b];
      BMU_OP_ST:   begin nd[b] = nc; wb = 1'b1; end
      default:     begin nd[b] = ~nc; wb = 1'b1; end
    endcase
    if (m) i_bmu_mem_model.mem_arr[a[7:0]] = d;
    run_op(o, m, fr, bi, br, d, a);
    exp_ccr[0] = nc;
    exp_ccr[2] = nz;
    check_bit("done", 1'b1, saw_done);
    check_bit("not refused", 1'b0, saw_ill);
    check_bit("busy while running", 1'b1, saw_busy);
    check_bit("busy at done", 1'b0, busy);
    check_byte("ccr", exp_ccr, condition_code_register);
    check_bit("byte written", wb, m ? saw_wr : saw_we);
    check_bit("memory read", m, saw_rd);
    if (m && wb) begin
      check_bit("read before write", 1'b1, rd_first);
      check_bit("same address", 1'b1, rd_addr === a && wr_addr === a);
      check_byte("memory byte", nd, i_bmu_mem_model.mem_arr[a[7:0]]);
    end
    if (!m && wb) check_byte("register byte", nd, we_data);
  endtask

  // ********
  // scenarios
  // ********
  // every opcode with carry both clear and set beforehand
  task automatic test_reg_ops();
    for (int i = 0; i < 14; i++) begin
      for (int c = 0; c < 2; c++) begin
        do_op(BMU_OP_LD, 0, 0, 3'h0, 8'h00, {8{c[0]}}, 16'h0);
        do_op(bmu_op_t'(i[3:0]), 0, 0, 3'(i + 3 * c), 8'h00, 8'h5a,
              16'h0);
      end
    end
  endtask
  // register bit numbers use only the low three bits
  task automatic test_reg_bitno();
    do_op(BMU_OP_SET, 0, 1, 3'h0, 8'hfd, 8'h00, 16'h0);
    do_op(BMU_OP_CLR, 0, 1, 3'h7, 8'hf8, 8'hff, 16'h0);
    do_op(BMU_OP_TST, 0, 1, 3'h0, 8'h0b, 8'h5a, 16'h0);
  endtask
  // inverted forms refuse a register bit number
  task automatic test_illegal();
    bmu_op_t inv [5] = '{BMU_OP_IAND, BMU_OP_IOR, BMU_OP_IXOR,
                         BMU_OP_ILD, BMU_OP_IST};
    foreach (inv[k]) begin
      run_op(inv[k], 0, 1, 3'h0, 8'h01, 8'h00, 16'h0);
      check_bit("refused", 1'b1, saw_ill);
      check_bit("no completion", 1'b0, saw_done);
      check_bit("never busy", 1'b0, saw_busy);
      check_byte("ccr kept", exp_ccr, condition_code_register);
    end
  endtask
  // memory operands with a prompt and a slow memory
  task automatic test_mem_ops();
    for (int l = 0; l < 4; l += 3) begin
      lat <= 2'(l);
      do_op(BMU_OP_SET, 1, 0, 3'h7, 8'h00, 8'h3c, 16'h1240);
      do_op(BMU_OP_CLR, 1, 0, 3'h2, 8'h00, 8'h3c, 16'h1241);
      do_op(BMU_OP_NOT, 1, 0, 3'h0, 8'h00, 8'h3c, 16'h12ff);
      do_op(BMU_OP_TST, 1, 0, 3'h6, 8'h00, 8'h3c, 16'h0010);
      do_op(BMU_OP_LD, 1, 0, 3'h5, 8'h00, 8'h3c, 16'h0011);
      do_op(BMU_OP_ST, 1, 0, 3'h0, 8'h00, 8'h00, 16'h8020);
      do_op(BMU_OP_IST, 1, 0, 3'h2, 8'h00, 8'hff, 16'h8021);
    end
  endtask
  // software clearing one bit of a write-only byte gets ones elsewhere
  task automatic test_write_only();
    wo_mode = 1'b1;
    do_op(BMU_OP_CLR, 1, 0, 3'h0, 8'h00, 8'h3f, 16'h00a0);
    wo_mode = 1'b0;
  endtask
  // reset during a memory sequence abandons it and clears the flags
  task automatic test_mid_reset();
    @(posedge clk);
    op           <= BMU_OP_SET;
    use_mem      <= 1'b1;
    bit_from_reg <= 1'b0;
    start        <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    exp_ccr = 8'h00;
    #1;
    check_bit("busy after mid reset", 1'b0, busy);
    check_byte("ccr after mid reset", exp_ccr, condition_code_register);
  endtask

  initial begin
    {sys_rst, start, use_mem, bit_from_reg, mem_write_only} = 5'h10;
    op = BMU_OP_SET;
    {bit_imm, bit_reg, reg_data, mem_addr_in} = '0;
    {lat, exp_ccr, wo_mode, mismatches, comparisons, cycles} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check_byte("ccr after reset", 8'h00, condition_code_register);
    test_reg_ops();
    test_reg_bitno();
    test_illegal();
    test_mem_ops();
    test_mid_reset();
    test_write_only();
    give_verdict();
  end
endmodule
